// File: src/dim_top.sv
`timescale 1ns/1ps
// ddr2 command decode, mode registers, burst sequencer and strobe options
// How it works
// - bursts run four or eight beats, in sequential or interleaved order
// - activate stores bank row; access needs activate
// - access address gives column and auto-precharge
// - mode register undefined until written
// - mode write decoded, opcode from a0-a13
// - register writes never touch array contents
// - mode register fields at documented positions
// - emr1 a11 turns mask pin into strobe
// - emr1 a10 floats complementary strobes
// - emr1 write decoded with ba0 high
module dim_top (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        CKE,
    input  wire logic        CS_N,
    input  wire logic        RAS_N,
    input  wire logic        CAS_N,
    input  wire logic        WE_N,
    input  wire logic [2:0]  BA,
    input  wire logic [13:0] ADDR,
    output logic      [13:0] MODE_REG,
    output logic      [13:0] EXT1_REG,
    output logic      [13:0] EXT2_REG,
    output logic      [13:0] EXT3_REG,
    output logic             MODE_VALID,
    output logic             DLL_LOCKED,
    output logic             OCD_ACTIVE,
    output logic             BURST_ACTIVE,
    output logic             BURST_WRITE,
    output logic      [2:0]  BURST_BANK,
    output logic      [13:0] BURST_ROW,
    output logic      [9:0]  BURST_COL,
    output logic             BURST_AUTOPRE,
    output logic             ACCESS_ERR,
    output logic             DM_IS_RDQS,
    output logic             RDQS_OE,
    output logic             DQS_N_OE,
    output logic             DM_MASK_EN
);
    //////////////////////////////////////////////////////////////////////
    // pin sampling: the command bus arrives from off chip
    logic [21:0] pin_s1_reg;
    logic [21:0] pin_s2_reg;
    always_ff @(posedge CORE_CLK) begin
        pin_s1_reg <= {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
        pin_s2_reg <= pin_s1_reg;
    end

    logic        cke_s;
    logic [3:0]  cmd_s;
    logic [2:0]  ba_s;
    logic [13:0] addr_s;
    assign cke_s  = pin_s2_reg[21];
    assign cmd_s  = pin_s2_reg[20:17];
    assign ba_s   = pin_s2_reg[16:14];
    assign addr_s = pin_s2_reg[13:0];

    // command decode, used for several command kinds
    function automatic logic is_cmd(input logic [3:0] c, input logic [3:0] code);
        is_cmd = (c == code);
    endfunction

    logic mrs_any;
    logic act_cmd;
    logic rd_cmd;
    logic wr_cmd;
    assign mrs_any = cke_s && is_cmd(cmd_s, dim_pkg::CMD_MRS);
    assign act_cmd = cke_s && is_cmd(cmd_s, dim_pkg::CMD_ACT);
    assign rd_cmd  = cke_s && is_cmd(cmd_s, dim_pkg::CMD_RD);
    assign wr_cmd  = cke_s && is_cmd(cmd_s, dim_pkg::CMD_WR);

    //////////////////////////////////////////////////////////////////////
    // mode and extended registers; they never reach the array
    logic [13:0] mr_reg, mr_next;
    logic [13:0] e1_reg, e1_next;
    logic [13:0] e2_reg, e2_next;
    logic [13:0] e3_reg, e3_next;
    logic        mvalid_reg, mvalid_next;
    logic [7:0]  lock_reg, lock_next;
    logic        locked_reg, locked_next;

    always_comb begin
        mr_next     = mr_reg;
        e1_next     = e1_reg;
        e2_next     = e2_reg;
        e3_next     = e3_reg;
        mvalid_next = mvalid_reg;
        lock_next   = lock_reg;
        locked_next = locked_reg;
        if (lock_reg != 8'h00) begin
            lock_next = lock_reg - dim_pkg::LOCK_ONE;
            if (lock_reg == dim_pkg::LOCK_ONE) begin
                locked_next = 1'b1;
            end
        end
        if (mrs_any) begin
            case (ba_s)
                dim_pkg::BA_MR: begin
                    mr_next     = addr_s;
                    mvalid_next = 1'b1;
                    if (addr_s[dim_pkg::MR_DLLR]) begin
                        lock_next   = dim_pkg::DLL_LOCK_CLKS;
                        locked_next = 1'b0;
                    end
                end
                dim_pkg::BA_EMR1: begin
                    e1_next = addr_s;
                    if (addr_s[dim_pkg::E1_DLL]) begin
                        locked_next = 1'b0; // dll disabled
                    end
                end
                dim_pkg::BA_EMR2: e2_next = addr_s;
                dim_pkg::BA_EMR3: e3_next = addr_s;
                default: ;
            endcase
        end
    end

    // mode register state, undefined contents modelled as zero
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mr_reg     <= 14'h0000;
            e1_reg     <= 14'h0000;
            e2_reg     <= 14'h0000;
            e3_reg     <= 14'h0000;
            mvalid_reg <= 1'b0;
            lock_reg   <= 8'h00;
            locked_reg <= 1'b0;
        end else begin
            mr_reg     <= mr_next;
            e1_reg     <= e1_next;
            e2_reg     <= e2_next;
            e3_reg     <= e3_next;
            mvalid_reg <= mvalid_next;
            lock_reg   <= lock_next;
            locked_reg <= locked_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // open-row memory per bank, written on activate
    logic [7:0]  open_reg, open_next;
    logic [13:0] row_rd;
    dim_regfile dim_regfile_i (
        .clk      (CORE_CLK),
        .we       (act_cmd),
        .waddr    (ba_s),
        .wdata    (addr_s),
        .raddr    (ba_s),
        .rdata    (row_rd)
    );

    //////////////////////////////////////////////////////////////////////
    // burst sequencer
    typedef enum logic [1:0] {DIM_IDLE, DIM_FETCH, DIM_BURST} dim_state_e;
    dim_state_e  st_reg, st_next;
    logic [3:0]  beat_reg, beat_next;
    logic [3:0]  len_reg, len_next;
    logic [9:0]  start_reg, start_next;
    logic [9:0]  col_reg, col_next;
    logic        inter_reg, inter_next;
    logic        wr_reg, wr_next;
    logic        ap_reg, ap_next;
    logic [2:0]  bank_reg, bank_next;
    logic [13:0] row_reg, row_next;
    logic        err_reg, err_next;
    logic        act_reg, act_next;
    logic [2:0]  lowbits;
    logic [2:0]  lenmask;

    always_comb begin
        st_next    = st_reg;
        beat_next  = beat_reg;
        len_next   = len_reg;
        start_next = start_reg;
        col_next   = col_reg;
        inter_next = inter_reg;
        wr_next    = wr_reg;
        ap_next    = ap_reg;
        bank_next  = bank_reg;
        row_next   = row_reg;
        err_next   = 1'b0;
        act_next   = 1'b0;
        open_next  = open_reg;
        lenmask    = (len_reg == dim_pkg::BEATS_8) ? 3'h7 : 3'h3;
        // sequential wraps by adding, interleaved by xor within the block
        lowbits    = inter_reg ? (start_reg[2:0] ^ beat_reg[2:0])
                               : (start_reg[2:0] + beat_reg[2:0]);
        if (act_cmd) begin
            open_next[ba_s] = 1'b1;
        end
        if (mrs_any && ba_s == dim_pkg::BA_MR) begin
            open_next = 8'h00; // only legal with all banks precharged
        end
        if (cke_s && is_cmd(cmd_s, dim_pkg::CMD_PRE)) begin
            if (addr_s[dim_pkg::AP_BIT]) begin
                open_next = 8'h00;
            end else begin
                open_next[ba_s] = 1'b0;
            end
        end
        case (st_reg)
            DIM_IDLE: begin
                if (rd_cmd || wr_cmd) begin
                    if (!open_reg[ba_s]) begin
                        err_next = 1'b1;
                    end else begin
                        st_next    = DIM_FETCH;
                        wr_next    = wr_cmd;
                        bank_next  = ba_s;
                        start_next = addr_s[dim_pkg::COL_W-1:0];
                        ap_next    = addr_s[dim_pkg::AP_BIT];
                        inter_next = mr_reg[dim_pkg::MR_BT];
                        len_next   = (mr_reg[dim_pkg::MR_BL_HI:dim_pkg::MR_BL_LO]
                                      == dim_pkg::BL_8) ? dim_pkg::BEATS_8
                                                        : dim_pkg::BEATS_4;
                        beat_next  = 4'h0;
                    end
                end
            end
            DIM_FETCH: begin
                row_next = row_rd;
                st_next  = DIM_BURST;
            end
            DIM_BURST: begin
                act_next  = 1'b1;
                col_next  = {start_reg[9:3], (start_reg[2:0] & ~lenmask)
                             | (lowbits & lenmask)};
                beat_next = beat_reg + dim_pkg::BEAT_ONE;
                if (beat_reg + dim_pkg::BEAT_ONE == len_reg) begin
                    st_next = DIM_IDLE;
                    if (ap_reg) begin
                        open_next[bank_reg] = 1'b0; // auto precharge closes row
                    end
                end
            end
            default: st_next = DIM_IDLE;
        endcase
    end

    // burst sequencer state
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st_reg    <= DIM_IDLE;
            beat_reg  <= 4'h0;
            len_reg   <= dim_pkg::BEATS_4;
            start_reg <= 10'h000;
            col_reg   <= 10'h000;
            inter_reg <= 1'b0;
            wr_reg    <= 1'b0;
            ap_reg    <= 1'b0;
            bank_reg  <= 3'h0;
            row_reg   <= 14'h0000;
            err_reg   <= 1'b0;
            act_reg   <= 1'b0;
            open_reg  <= 8'h00;
        end else begin
            st_reg    <= st_next;
            beat_reg  <= beat_next;
            len_reg   <= len_next;
            start_reg <= start_next;
            col_reg   <= col_next;
            inter_reg <= inter_next;
            wr_reg    <= wr_next;
            ap_reg    <= ap_next;
            bank_reg  <= bank_next;
            row_reg   <= row_next;
            err_reg   <= err_next;
            act_reg   <= act_next;
            open_reg  <= open_next;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // strobe options from extended register 1, registered to the pins
    logic rdqs_en_reg, dqsn_oe_reg, qoff_ocd_reg, rdqs_oe_reg, mask_en_reg;
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdqs_en_reg  <= 1'b0;
            dqsn_oe_reg  <= 1'b0;
            qoff_ocd_reg <= 1'b0;
            rdqs_oe_reg  <= 1'b0;
            mask_en_reg  <= 1'b1;
        end else begin
            rdqs_en_reg  <= e1_next[dim_pkg::E1_RDQS];
            mask_en_reg  <= !e1_next[dim_pkg::E1_RDQS];
            rdqs_oe_reg  <= e1_next[dim_pkg::E1_RDQS] && act_next && !wr_next
                            && !e1_next[dim_pkg::E1_DQSN] && !e1_next[dim_pkg::E1_QOFF];
            dqsn_oe_reg  <= act_next && !wr_next && !e1_next[dim_pkg::E1_DQSN]
                            && !e1_next[dim_pkg::E1_QOFF];
            qoff_ocd_reg <= e1_next[dim_pkg::E1_OCD_HI:dim_pkg::E1_OCD_LO]
                            != dim_pkg::OCD_EXIT;
        end
    end

    assign MODE_REG      = mr_reg;
    assign EXT1_REG      = e1_reg;
    assign EXT2_REG      = e2_reg;
    assign EXT3_REG      = e3_reg;
    assign MODE_VALID    = mvalid_reg;
    assign DLL_LOCKED    = locked_reg;
    assign OCD_ACTIVE    = qoff_ocd_reg;
    assign BURST_ACTIVE  = act_reg;
    assign BURST_WRITE   = wr_reg;
    assign BURST_BANK    = bank_reg;
    assign BURST_ROW     = row_reg;
    assign BURST_COL     = col_reg;
    assign BURST_AUTOPRE = ap_reg;
    assign ACCESS_ERR    = err_reg;
    assign DM_IS_RDQS    = rdqs_en_reg;
    assign RDQS_OE       = rdqs_oe_reg;
    assign DQS_N_OE      = dqsn_oe_reg;
    assign DM_MASK_EN    = mask_en_reg;
endmodule

// File: shared/dim_pkg.sv
// package of command codes, field positions and constants for the ddr2 mode block
package dim_pkg;
    localparam int ADDR_W = 14;
    localparam int BA_W   = 3;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_MRS  = 4'h0;
    localparam logic [3:0] CMD_REF  = 4'h1;
    localparam logic [3:0] CMD_PRE  = 4'h2;
    localparam logic [3:0] CMD_ACT  = 4'h3;
    localparam logic [3:0] CMD_WR   = 4'h4;
    localparam logic [3:0] CMD_RD   = 4'h5;
    // bank codes selecting mode registers
    localparam logic [2:0] BA_MR    = 3'h0;
    localparam logic [2:0] BA_EMR1  = 3'h1;
    localparam logic [2:0] BA_EMR2  = 3'h2;
    localparam logic [2:0] BA_EMR3  = 3'h3;
    // mode register fields
    localparam int MR_BL_LO = 0;
    localparam int MR_BL_HI = 2;
    localparam int MR_BT    = 3;
    localparam int MR_CL_LO = 4;
    localparam int MR_CL_HI = 6;
    localparam int MR_TM    = 7;
    localparam int MR_DLLR  = 8;
    localparam int MR_WR_LO = 9;
    localparam int MR_WR_HI = 11;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    // extended register 1 fields
    localparam int E1_DLL   = 0;
    localparam int E1_OCD_LO = 7;
    localparam int E1_OCD_HI = 9;
    localparam int E1_DQSN  = 10;
    localparam int E1_RDQS  = 11;
    localparam int E1_QOFF  = 12;
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DEF  = 3'h7;
    localparam int COL_W    = 10;
    localparam int AP_BIT   = 10;
    localparam logic [3:0] BEATS_4 = 4'h4;
    localparam logic [3:0] BEATS_8 = 4'h8;
    // dll lock wait after reset, in clocks
    localparam logic [7:0] DLL_LOCK_CLKS = 8'hC8;
    localparam logic [7:0] LOCK_ONE      = 8'h01;
    localparam logic [3:0] BEAT_ONE      = 4'h1;
    localparam logic [2:0] BANKS         = 3'h7;
endpackage

// File: src/dim_regfile.sv
`timescale 1ns/1ps
// small per-bank open-row memory with registered read data
module dim_regfile (
    input  wire logic        clk,
    input  wire logic        we,
    input  wire logic [2:0]  waddr,
    input  wire logic [13:0] wdata,
    input  wire logic [2:0]  raddr,
    output logic      [13:0] rdata
);
    logic [13:0] mem [0:7];

    // write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// File: bench/dim_top_sva.sv
// concurrent checks on the ports of the ddr2 mode register block
`timescale 1ns/1ps
module dim_top_sva (
    input wire logic        CORE_CLK,
    input wire logic        RST,
    input wire logic        CKE,
    input wire logic        CS_N,
    input wire logic        RAS_N,
    input wire logic        CAS_N,
    input wire logic        WE_N,
    input wire logic [2:0]  BA,
    input wire logic [13:0] ADDR,
    input wire logic [13:0] MODE_REG,
    input wire logic [13:0] EXT1_REG,
    input wire logic        MODE_VALID,
    input wire logic        DLL_LOCKED,
    input wire logic        BURST_ACTIVE,
    input wire logic [9:0]  BURST_COL,
    input wire logic        ACCESS_ERR
);
    logic [9:0] blk_m;
    logic [7:0] lo_cnt_reg;
    logic [7:0] lo_cnt_next;
    ////////////////////////////////////////////////////////////////
    // burst block mask and a saturating count of cycles without lock
    always_comb begin
        blk_m = (MODE_REG[2:0] == dim_pkg::BL_8) ? 10'h007 : 10'h003;
        lo_cnt_next = DLL_LOCKED ? 8'h00 : lo_cnt_reg + {7'h00, lo_cnt_reg != 8'hFF};
    end
    // count register
    always_ff @(posedge CORE_CLK) begin
        lo_cnt_reg <= RST ? 8'h00 : lo_cnt_next;
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    property p_mrld;
        {CS_N, RAS_N, CAS_N, WE_N, BA} == {dim_pkg::CMD_MRS, dim_pkg::BA_MR} ##0 CKE[*3]
            |=> MODE_REG == $past(ADDR, 3);
    endproperty
    a_mrld: assert property (p_mrld) else $error("mode reg load");
    property p_e1ld;
        {CS_N, RAS_N, CAS_N, WE_N, BA} == {dim_pkg::CMD_MRS, dim_pkg::BA_EMR1} ##0 CKE[*3]
            |=> EXT1_REG == $past(ADDR, 3);
    endproperty
    a_e1ld: assert property (p_e1ld) else $error("ext1 load");
    property p_bl4;
        $rose(BURST_ACTIVE) && MODE_REG[2:0] == dim_pkg::BL_4 |-> BURST_ACTIVE[*4] ##1 !BURST_ACTIVE;
    endproperty
    a_bl4: assert property (p_bl4) else $error("burst of four");
    property p_bl8;
        $rose(BURST_ACTIVE) && MODE_REG[2:0] == dim_pkg::BL_8 |-> BURST_ACTIVE[*8] ##1 !BURST_ACTIVE;
    endproperty
    a_bl8: assert property (p_bl8) else $error("burst of eight");
    property p_walk;
        BURST_ACTIVE && $past(BURST_ACTIVE) && !MODE_REG[3] |->
            BURST_COL == (($past(BURST_COL) & ~blk_m) | (($past(BURST_COL) + 10'h001) & blk_m));
    endproperty
    a_walk: assert property (p_walk) else $error("sequential column walk");
    property p_dll;
        $rose(DLL_LOCKED) |-> lo_cnt_reg >= 8'hC6;
    endproperty
    a_dll: assert property (p_dll) else $error("dll lock too early");
    property p_err;
        ACCESS_ERR |=> !ACCESS_ERR;
    endproperty
    a_err: assert property (p_err) else $error("error not a pulse");
    property p_valid;
        MODE_VALID |=> MODE_VALID;
    endproperty
    a_valid: assert property (p_valid) else $error("mode valid dropped");
    c_burst: cover property ($rose(BURST_ACTIVE));
    c_err: cover property (ACCESS_ERR);
    c_lock: cover property ($rose(DLL_LOCKED));
endmodule

// File: bench/dim_ctl.sv
// controller model driving the ddr2 command and address pins
`timescale 1ns/1ps
module dim_ctl #(
    parameter int          PWR_CLKS = 4000,      // 200us of stable clock at 50ns
    parameter logic [13:0] MR_RUN   = 14'h0652   // bl4 seq cl5, wr code rounded up
) (
    input wire logic        clk,
    output logic            cke,
    output logic            cs_n,
    output logic            ras_n,
    output logic            cas_n,
    output logic            we_n,
    output logic     [2:0]  ba,
    output logic     [13:0] addr
);
    ////////////////////////////////////////////////////////////////
    // cke low and device deselected while power settles
    initial begin
        {cke, cs_n, ras_n, cas_n, we_n} = 5'h0F;
        ba = 3'h0;
        addr = 14'h0000;
    end
    // one command for one cycle, then deselect with scrambled lines
    task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge clk);
        {cs_n, ras_n, cas_n, we_n} = c;
        ba = b;
        addr = a;
        @(negedge clk); // one idle cycle covers the register write cycle time
        cs_n = 1'b1;
        ba = ~b;
        addr = ~a;
    endtask
    // power-up sequence with idle waits between steps
    task automatic power_up();
        repeat (PWR_CLKS) @(negedge clk);
        cke = 1'b1;
        repeat (8) @(negedge clk); // 400ns of deselect
        issue(dim_pkg::CMD_PRE, 3'h0, 14'h0400);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR2, 14'h0000);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR3, 14'h0000);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, 14'h0000);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_MR, MR_RUN | 14'h0100);
        issue(dim_pkg::CMD_PRE, 3'h0, 14'h0400);
        issue(dim_pkg::CMD_REF, 3'h0, 14'h0000);
        issue(dim_pkg::CMD_REF, 3'h0, 14'h0000);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_MR, MR_RUN);
        repeat (200) @(negedge clk);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, 14'h0380);
        issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, 14'h0000);
    endtask
endmodule

// File: bench/test_ddr2_init_and_mode_registers.sv
// self-checking bench for the ddr2 mode register block
`timescale 1ns/1ps
bind dim_top dim_top_sva dim_top_sva_i (
    .CORE_CLK(CORE_CLK), .RST(RST), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
    .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .MODE_REG(MODE_REG),
    .EXT1_REG(EXT1_REG), .MODE_VALID(MODE_VALID), .DLL_LOCKED(DLL_LOCKED),
    .BURST_ACTIVE(BURST_ACTIVE), .BURST_COL(BURST_COL), .ACCESS_ERR(ACCESS_ERR)
);
module test_ddr2_init_and_mode_registers;
    localparam logic [13:0] MR_RUN = 14'h0652;
    logic        core_clk, rst, cke, cs_n, ras_n, cas_n, we_n;
    logic [2:0]  ba, burst_bank;
    logic [13:0] addr, mode_reg, ext1_reg, ext2_reg, ext3_reg, burst_row;
    logic [9:0]  burst_col;
    logic        mode_valid, dll_locked, ocd_active, burst_active, burst_write;
    logic        burst_autopre, access_err, dm_is_rdqs, dqs_n_oe, dm_mask_en, rdqs_oe;
    int          num_errors = 0;
    int          n_checks = 0;
    ////////////////////////////////////////////////////////////////
    // clock and instances
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    dim_top dim_top_i (.CORE_CLK(core_clk), .RST(rst), .CKE(cke), .CS_N(cs_n),
        .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr),
        .MODE_REG(mode_reg), .EXT1_REG(ext1_reg), .EXT2_REG(ext2_reg), .EXT3_REG(ext3_reg),
        .MODE_VALID(mode_valid), .DLL_LOCKED(dll_locked), .OCD_ACTIVE(ocd_active),
        .BURST_ACTIVE(burst_active), .BURST_WRITE(burst_write), .BURST_BANK(burst_bank),
        .BURST_ROW(burst_row), .BURST_COL(burst_col), .BURST_AUTOPRE(burst_autopre),
        .ACCESS_ERR(access_err), .DM_IS_RDQS(dm_is_rdqs), .RDQS_OE(rdqs_oe),
        .DQS_N_OE(dqs_n_oe), .DM_MASK_EN(dm_mask_en));
    dim_ctl #(.MR_RUN(MR_RUN)) dim_ctl_i (.clk(core_clk), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
    ////////////////////////////////////////////////////////////////
    // compare words and flags, count and report
    task automatic chk(input string s, input logic [13:0] e, input logic [13:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic chk1(input string s, input logic e, input logic g);
        chk(s, {13'h0000, e}, {13'h0000, g});
    endtask
    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset values, then the full power-up sequence
    task automatic t_init();
        chk1("valid", 1'b0, mode_valid);
        chk1("mask", 1'b1, dm_mask_en);
        dim_ctl_i.power_up();
        settle();
        chk("mr", MR_RUN, mode_reg);
        chk("e1", 14'h0000, ext1_reg);
        chk("e2", 14'h0000, ext2_reg);
        chk("e3", 14'h0000, ext3_reg);
        chk1("valid", 1'b1, mode_valid);
        chk1("dll", 1'b1, dll_locked);
        $display("t_init done");
    endtask
    // driver calibration default then exit
    task automatic t_ocd();
        dim_ctl_i.issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, 14'h0380);
        settle();
        chk1("ocd on", 1'b1, ocd_active);
        dim_ctl_i.issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, 14'h0000);
        settle();
        chk1("ocd off", 1'b0, ocd_active);
        $display("t_ocd done");
    endtask
    // dll reset in mid-run and the lock wait
    task automatic t_dll();
        logic [13:0] k;
        k = 14'h0000;
        dim_ctl_i.issue(dim_pkg::CMD_MRS, dim_pkg::BA_MR, MR_RUN | 14'h0100);
        settle();
        chk1("dll low", 1'b0, dll_locked);
        chk("mr", MR_RUN | 14'h0100, mode_reg);
        while (dll_locked !== 1'b1 && k < 14'h012C) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk1("lock time", 1'b1, k >= 14'h00C4 && k <= 14'h00CC);
        $display("t_dll done");
    endtask
    // program mode and strobes, open a row, run one access and walk its beats
    task automatic t_burst(input logic [2:0] bl, input logic bt, input logic wr,
                           input logic [9:0] st, input logic [13:0] e1);
        logic [9:0]  m;
        logic [9:0]  ex;
        logic [13:0] n;
        m = (bl == dim_pkg::BL_8) ? 10'h007 : 10'h003;
        n = 14'h0000;
        dim_ctl_i.issue(dim_pkg::CMD_MRS, dim_pkg::BA_MR, {5'h03, 2'h0, 3'h5, bt, bl});
        dim_ctl_i.issue(dim_pkg::CMD_MRS, dim_pkg::BA_EMR1, e1);
        dim_ctl_i.issue(dim_pkg::CMD_ACT, 3'h5, 14'h1ABC);
        dim_ctl_i.issue(wr ? dim_pkg::CMD_WR : dim_pkg::CMD_RD, 3'h5, {4'h1, st});
        repeat (12) begin
            @(posedge core_clk);
            #1;
            if (burst_active === 1'b1) begin
                ex = bt ? (st ^ n[9:0]) : (st + n[9:0]);
                chk("col", {4'h0, (st & ~m) | (ex & m)}, {4'h0, burst_col});
                chk("row", 14'h1ABC, burst_row);
                chk("bank", 14'h0005, {11'h000, burst_bank});
                chk1("ap", 1'b1, burst_autopre);
                chk1("wr", wr, burst_write);
                chk1("dqsn", !wr && !e1[10], dqs_n_oe);
                chk1("rdqsoe", e1[11] && !wr && !e1[10], rdqs_oe);
                n++;
            end
        end
        chk("beats", (bl == dim_pkg::BL_8) ? 14'h0008 : 14'h0004, n);
        chk1("rdqs", e1[11], dm_is_rdqs);
        chk1("mask", !e1[11], dm_mask_en);
        $display("t_burst done");
    endtask
    // read with every bank closed is refused
    task automatic t_err();
        logic [13:0] ne;
        logic [13:0] nb;
        ne = 14'h0000;
        nb = 14'h0000;
        dim_ctl_i.issue(dim_pkg::CMD_PRE, 3'h0, 14'h0400);
        dim_ctl_i.issue(dim_pkg::CMD_RD, 3'h2, 14'h0005);
        repeat (10) begin
            @(posedge core_clk);
            #1;
            ne = ne + {13'h0000, access_err};
            nb = nb + {13'h0000, burst_active};
        end
        chk("err", 14'h0001, ne);
        chk("beats", 14'h0000, nb);
        $display("t_err done");
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_init();
        t_ocd();
        t_dll();
        t_burst(dim_pkg::BL_4, 1'b0, 1'b0, 10'h00D, 14'h0000);
        t_burst(dim_pkg::BL_8, 1'b1, 1'b1, 10'h3FE, 14'h0800);
        t_burst(dim_pkg::BL_8, 1'b0, 1'b0, 10'h3FB, 14'h0C00);
        t_burst(dim_pkg::BL_4, 1'b1, 1'b0, 10'h00D, 14'h0400);
        t_err();
        tally_and_finish();
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        $display("FAIL watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule
